// *** src/lcr_pkg.sv ***
// constants of the segment display driver control register bank
// assumes a 32-bit AXI4-Lite bus with one aligned word per register
package lcr_pkg;
    // register byte addresses
    localparam logic [7:0] A_CLK  = 8'h00;
    localparam logic [7:0] A_CTL  = 8'h04;
    localparam logic [7:0] A_TIM1 = 8'h08;
    localparam logic [7:0] A_TIM2 = 8'h0C;
    localparam logic [7:0] A_PWR  = 8'h10;
    localparam logic [7:0] A_DSP  = 8'h14;
    localparam logic [7:0] A_COM  = 8'h18;
    localparam logic [7:0] A_INTF = 8'h1C;
    localparam logic [7:0] A_INTE = 8'h20;
    // writable bits of each register, the rest read zero
    localparam logic [15:0] M_CLK  = 16'h0173;
    localparam logic [15:0] M_CTL  = 16'h0003;
    localparam logic [15:0] M_TIM1 = 16'h1F0F;
    localparam logic [15:0] M_TIM2 = 16'h030F;
    localparam logic [15:0] M_PWR  = 16'h8F1D;
    localparam logic [15:0] M_DSP  = 16'h0077;
    localparam logic [15:0] M_COM  = 16'hFFFF;
    localparam logic [15:0] M_INT  = 16'h0001;
    // reset values
    localparam logic [15:0] R_CLK  = 16'h0100;
    localparam logic [15:0] R_CTL  = 16'h0000;
    localparam logic [15:0] R_TIM1 = 16'h030F;
    localparam logic [15:0] R_TIM2 = 16'h0100;
    localparam logic [15:0] R_PWR  = 16'h8000;
    localparam logic [15:0] R_DSP  = 16'h0070;
    localparam logic [15:0] R_COM  = 16'hFFFF;
    localparam logic [15:0] R_INT  = 16'h0000;
    // field positions
    localparam int P_DEBUG_RUN = 8;
    localparam int P_DIV   = 4;
    localparam int P_SRC   = 0;
    localparam int P_DIS   = 1;
    localparam int P_MODULE_ENABLE = 0;
    localparam int P_FRM   = 8;
    localparam int P_DUTY  = 0;
    localparam int P_BOOSTER_CLOCK_SEL  = 8;
    localparam int P_INVERSE_LINE_COUNT = 0;
    localparam int P_EXVC  = 15;
    localparam int P_LC    = 8;
    localparam int P_BOOSTER_ENABLE = 4;
    localparam int P_BIAS  = 3;
    localparam int P_HEAVY_LOAD_PROTECT  = 2;
    localparam int P_REGULATOR_ENABLE  = 0;
    localparam int P_SEG   = 6;
    localparam int P_COMO  = 5;
    localparam int P_INV   = 4;
    localparam int P_AREA  = 2;
    localparam int P_DISPLAY_ONOFF_MODE  = 0;
    localparam int P_FLAG  = 0;
    // clock sources and division, display field codes and bus responses
    localparam logic [1:0] SRC_INT  = 2'h0;
    localparam logic [1:0] SRC_LOW  = 2'h1;
    localparam logic [1:0] SRC_HIGH = 2'h2;
    localparam logic [1:0] SRC_EXT  = 2'h3;
    localparam logic [2:0] DIV_MAX  = 3'h5;
    localparam logic [9:0] DIV_BASE = 10'h010;
    localparam logic [5:0] BST_L0   = 6'h03;
    localparam logic [5:0] BST_L1   = 6'h0F;
    localparam logic [5:0] BST_L2   = 6'h1F;
    localparam logic [5:0] BST_L3   = 6'h3F;
    localparam logic [1:0] DISPLAY_ONOFF_MODE_OFF = 2'h0;
    localparam logic [3:0] INVERSE_LINE_COUNT_NORMAL = 4'h0;
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

// *** src/lcr_regs.sv ***
// control and status register bank of the segment display driver
// assumes source ticks, halt and frame events come from core_clk logic
module lcr_regs #(
    parameter logic [3:0] SRC_SUPPORTED = 4'hF  // sources present on chip
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [3:0]             srcTick,
    input  wire logic                   dbgHalt,
    input  wire logic                   frameSwitch,
    output logic                        irqReq,
    output logic                        opClkEn,
    output logic                        bstClkEn,
    output logic [4:0]                  frameRateSel,
    output logic [3:0]                  driveDutySel,
    output logic [3:0]                  inverseLineCount,
    output logic                        nLineInvertOn,
    output logic                        externalSupplySel,
    output logic [3:0]                  contrastLevel,
    output logic                        boosterEnable,
    output logic                        biasSelect,
    output logic                        heavyLoadProtect,
    output logic                        regulatorEnable,
    output logic                        segmentOrder,
    output logic                        commonOrder,
    output logic                        displayInvertN,
    output logic                        displayAreaSel,
    output logic [1:0]                  displayOnoffMode,
    output logic                        pinsDriveLow,
    output logic                        pinsHiZ,
    output logic [15:0]                 commonPinDriveEn
);
    import lcr_pkg::*;

    // state of the block apart from the reset synchroniser
    typedef struct packed {
        logic        awHave;  // write address held
        logic [7:0]  awAddr;
        logic        wHave;   // write data held
        logic [15:0] wData;
        logic [1:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [15:0] rData;
        logic [1:0]  rResp;
        logic [15:0] clkReg;
        logic [15:0] ctlReg;
        logic [15:0] tim1Reg;
        logic [15:0] tim2Reg;
        logic [15:0] pwrReg;
        logic [15:0] dspReg;
        logic [15:0] comReg;
        logic [15:0] intfReg;
        logic [15:0] inteReg;
        logic [9:0]  divCnt;  // source divider
        logic [5:0]  bstCnt;  // booster divider
        logic        opTick;
        logic        bstTick;
    } lcr_state_t;

    lcr_state_t stReg;
    lcr_state_t stNext;
    logic [1:0] rstSync;  // reset release pipeline
    logic       rstN;     // synchronised reset

    // true when the address names a register
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == A_CLK) || (a == A_CTL) || (a == A_TIM1) ||
                   (a == A_TIM2) || (a == A_PWR) || (a == A_DSP) ||
                   (a == A_COM) || (a == A_INTF) || (a == A_INTE);
    endfunction

    // byte-lane merge limited to writable bits
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0]  stb,
                                          input logic [15:0] msk);
        logic [15:0] en;
        en = {{8{stb[1]}}, {8{stb[0]}}} & msk;
        merge = (old & ~en) | (dat & en);
    endfunction

    // booster divider terminal count
    function automatic logic [5:0] bstLimit(input logic [1:0] c);
        bstLimit = (c == 2'h0) ? BST_L0 : (c == 2'h1) ? BST_L1 :
                   (c == 2'h2) ? BST_L2 : BST_L3;
    endfunction

    // handshake outputs
    assign s_axi_awready = !stReg.awHave && !stReg.bValid;
    assign s_axi_wready  = !stReg.wHave && !stReg.bValid;
    assign s_axi_arready = !stReg.rValid;
    assign s_axi_bvalid  = stReg.bValid;
    assign s_axi_bresp   = stReg.bResp;
    assign s_axi_rvalid  = stReg.rValid;
    assign s_axi_rresp   = stReg.rResp;
    assign s_axi_rdata   = {16'h0000, stReg.rData};

    // field outputs
    assign frameRateSel      = stReg.tim1Reg[P_FRM +: 5];
    assign driveDutySel      = stReg.tim1Reg[P_DUTY +: 4];
    assign inverseLineCount  = stReg.tim2Reg[P_INVERSE_LINE_COUNT +: 4];
    assign nLineInvertOn     = inverseLineCount != INVERSE_LINE_COUNT_NORMAL;
    assign externalSupplySel = stReg.pwrReg[P_EXVC];
    assign contrastLevel     = stReg.pwrReg[P_LC +: 4];
    assign boosterEnable     = stReg.pwrReg[P_BOOSTER_ENABLE];
    assign biasSelect        = stReg.pwrReg[P_BIAS];
    assign heavyLoadProtect  = stReg.pwrReg[P_HEAVY_LOAD_PROTECT];
    assign regulatorEnable   = stReg.pwrReg[P_REGULATOR_ENABLE];
    assign segmentOrder      = stReg.dspReg[P_SEG];
    assign commonOrder       = stReg.dspReg[P_COMO];
    assign displayInvertN    = stReg.dspReg[P_INV];
    assign displayAreaSel    = stReg.dspReg[P_AREA];
    assign displayOnoffMode  = stReg.dspReg[P_DISPLAY_ONOFF_MODE +: 2];
    assign commonPinDriveEn  = stReg.comReg;
    assign opClkEn           = stReg.opTick;
    assign bstClkEn          = stReg.bstTick;

    // display off: discharge low or float the pins
    logic dispOff;
    assign dispOff      = displayOnoffMode == DISPLAY_ONOFF_MODE_OFF;
    assign pinsDriveLow = dispOff && stReg.ctlReg[P_DIS];
    assign pinsHiZ      = dispOff && !stReg.ctlReg[P_DIS];

    // interrupt request
    assign irqReq = stReg.intfReg[P_FLAG] && stReg.inteReg[P_FLAG];

    // divider helpers
    logic       runClk;  // operating clock allowed
    logic [1:0] src;
    logic [2:0] divSel;
    logic       bypass;
    assign src    = stReg.clkReg[P_SRC +: 2];
    assign divSel = stReg.clkReg[P_DIV +: 3];
    assign bypass = (src == SRC_LOW) || (src == SRC_EXT);
    assign runClk = stReg.ctlReg[P_MODULE_ENABLE] &&
                    (stReg.clkReg[P_DEBUG_RUN] || !dbgHalt);

    // next-state logic
    always_comb begin
        logic [15:0] nv;
        nv = 16'h0000;
        stNext = stReg;
        stNext.opTick = 1'b0;
        stNext.bstTick = 1'b0;
        // capture write address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            stNext.awHave = 1'b1;
            stNext.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            stNext.wHave = 1'b1;
            stNext.wData = s_axi_wdata[15:0];
            stNext.wStrb = s_axi_wstrb[1:0];
        end
        if (stReg.bValid && s_axi_bready) begin
            stNext.bValid = 1'b0;
        end
        // perform the write once both halves are held
        if (stReg.awHave && stReg.wHave && !stReg.bValid) begin
            stNext.awHave = 1'b0;
            stNext.wHave = 1'b0;
            stNext.bValid = 1'b1;
            stNext.bResp = isMapped(stReg.awAddr) ? RESP_OK : RESP_ERR;
            if (stReg.awAddr == A_CLK) begin
                // locked while the module runs
                if (!stReg.ctlReg[P_MODULE_ENABLE]) begin
                    nv = merge(stReg.clkReg, stReg.wData, stReg.wStrb, M_CLK);
                    // unsupported source keeps the old one
                    if (!SRC_SUPPORTED[nv[P_SRC +: 2]]) begin
                        nv[P_SRC +: 2] = src;
                    end
                    stNext.clkReg = nv;
                end
            end else if (stReg.awAddr == A_CTL) begin
                stNext.ctlReg = merge(stReg.ctlReg, stReg.wData, stReg.wStrb, M_CTL);
            end else if (stReg.awAddr == A_TIM1) begin
                stNext.tim1Reg = merge(stReg.tim1Reg, stReg.wData, stReg.wStrb, M_TIM1);
            end else if (stReg.awAddr == A_TIM2) begin
                stNext.tim2Reg = merge(stReg.tim2Reg, stReg.wData, stReg.wStrb, M_TIM2);
            end else if (stReg.awAddr == A_PWR) begin
                stNext.pwrReg = merge(stReg.pwrReg, stReg.wData, stReg.wStrb, M_PWR);
            end else if (stReg.awAddr == A_DSP) begin
                stNext.dspReg = merge(stReg.dspReg, stReg.wData, stReg.wStrb, M_DSP);
            end else if (stReg.awAddr == A_COM) begin
                stNext.comReg = merge(stReg.comReg, stReg.wData, stReg.wStrb, M_COM);
            end else if (stReg.awAddr == A_INTF) begin
                // ones clear, zeros leave the flag alone
                nv = merge(16'h0000, stReg.wData, stReg.wStrb, M_INT);
                stNext.intfReg = stReg.intfReg & ~nv;
            end else if (stReg.awAddr == A_INTE) begin
                stNext.inteReg = merge(stReg.inteReg, stReg.wData, stReg.wStrb, M_INT);
            end
        end
        // frame event sets the flag and beats a clear
        if (frameSwitch) begin
            stNext.intfReg[P_FLAG] = 1'b1;
        end
        // disabling the module switches the display off
        if (stReg.ctlReg[P_MODULE_ENABLE] && !stNext.ctlReg[P_MODULE_ENABLE]) begin
            stNext.dspReg[P_DISPLAY_ONOFF_MODE +: 2] = DISPLAY_ONOFF_MODE_OFF;
        end
        // read channel
        if (stReg.rValid && s_axi_rready) begin
            stNext.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            stNext.rValid = 1'b1;
            stNext.rResp = isMapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
            if (s_axi_araddr == A_CLK) begin
                stNext.rData = stReg.clkReg;
            end else if (s_axi_araddr == A_CTL) begin
                stNext.rData = stReg.ctlReg;
            end else if (s_axi_araddr == A_TIM1) begin
                stNext.rData = stReg.tim1Reg;
            end else if (s_axi_araddr == A_TIM2) begin
                stNext.rData = stReg.tim2Reg;
            end else if (s_axi_araddr == A_PWR) begin
                stNext.rData = stReg.pwrReg;
            end else if (s_axi_araddr == A_DSP) begin
                stNext.rData = stReg.dspReg;
            end else if (s_axi_araddr == A_COM) begin
                stNext.rData = stReg.comReg;
            end else if (s_axi_araddr == A_INTF) begin
                stNext.rData = stReg.intfReg;
            end else if (s_axi_araddr == A_INTE) begin
                stNext.rData = stReg.inteReg;
            end else begin
                stNext.rData = 16'h0000;
            end
        end
        // operating clock divider on the selected source
        if (!stReg.ctlReg[P_MODULE_ENABLE]) begin
            stNext.divCnt = 10'h000;
        end else if (runClk && srcTick[src]) begin
            if (bypass) begin
                stNext.opTick = 1'b1;
            end else if (divSel <= DIV_MAX) begin
                if (stReg.divCnt >= ((DIV_BASE << divSel) - 10'h001)) begin
                    stNext.divCnt = 10'h000;
                    stNext.opTick = 1'b1;
                end else begin
                    stNext.divCnt = stReg.divCnt + 10'h001;
                end
            end
        end
        // booster clock from the operating clock
        if (!stReg.ctlReg[P_MODULE_ENABLE]) begin
            stNext.bstCnt = 6'h00;
        end else if (stReg.opTick) begin
            if (stReg.bstCnt >= bstLimit(stReg.tim2Reg[P_BOOSTER_CLOCK_SEL +: 2])) begin
                stNext.bstCnt = 6'h00;
                stNext.bstTick = 1'b1;
            end else begin
                stNext.bstCnt = stReg.bstCnt + 6'h01;
            end
        end
    end

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // state register
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stReg <= '{clkReg: R_CLK, ctlReg: R_CTL, tim1Reg: R_TIM1, tim2Reg: R_TIM2,
                       pwrReg: R_PWR, dspReg: R_DSP, comReg: R_COM, intfReg: R_INT,
                       inteReg: R_INT, default: '0};
        end else begin
            stReg <= stNext;
        end
    end

    // frame event shows in the flag next cycle
    property p_flagSet;
        @(posedge core_clk) disable iff (!rstN)
        frameSwitch |=> stReg.intfReg[P_FLAG];
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("flag not set");

    // only a write of one clears the flag
    property p_flagHold;
        @(posedge core_clk) disable iff (!rstN)
        stReg.intfReg[P_FLAG] && !stNext.intfReg[P_FLAG] |->
        stReg.awAddr == A_INTF && stReg.wData[P_FLAG] && stReg.wStrb[0];
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("flag lost");

    // interrupt tracks flag and enable
    property p_irq;
        @(posedge core_clk) disable iff (!rstN)
        irqReq == (stReg.intfReg[P_FLAG] && stReg.inteReg[P_FLAG]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    // no operating clock in halt without debug-run
    property p_dbgStop;
        @(posedge core_clk) disable iff (!rstN)
        dbgHalt && !stReg.clkReg[P_DEBUG_RUN] |=> !opClkEn;
    endproperty
    a_dbgStop: assert property (p_dbgStop) else $error("clock in halt");

    // clock register frozen while enabled
    property p_clkLock;
        @(posedge core_clk) disable iff (!rstN)
        stReg.ctlReg[P_MODULE_ENABLE] |=> $stable(stReg.clkReg);
    endproperty
    a_clkLock: assert property (p_clkLock) else $error("clock reg changed");

    // disabled module produces no clock
    property p_noClk;
        @(posedge core_clk) disable iff (!rstN)
        !stReg.ctlReg[P_MODULE_ENABLE] |=> !opClkEn ##1 !bstClkEn;
    endproperty
    a_noClk: assert property (p_noClk) else $error("clock while off");

    // falling enable forces display off
    property p_modOff;
        @(posedge core_clk) disable iff (!rstN)
        $fell(stReg.ctlReg[P_MODULE_ENABLE]) |-> displayOnoffMode == DISPLAY_ONOFF_MODE_OFF;
    endproperty
    a_modOff: assert property (p_modOff) else $error("display left on");

    // pins low or floating only with display off
    property p_discharge;
        @(posedge core_clk) disable iff (!rstN)
        (pinsDriveLow || pinsHiZ) |-> dispOff && (pinsDriveLow != pinsHiZ) &&
        pinsDriveLow == stReg.ctlReg[P_DIS];
    endproperty
    a_discharge: assert property (p_discharge) else $error("pin mode wrong");

    // booster tick follows an operating tick
    property p_bst;
        @(posedge core_clk) disable iff (!rstN)
        bstClkEn |-> $past(opClkEn);
    endproperty
    a_bst: assert property (p_bst) else $error("booster tick alone");

    // reserved bits read zero
    property p_rsvd;
        @(posedge core_clk) disable iff (!rstN)
        s_axi_rdata[31:16] == 16'h0000 &&
        ((stReg.clkReg & ~M_CLK) | (stReg.ctlReg & ~M_CTL) | (stReg.tim1Reg & ~M_TIM1) |
         (stReg.tim2Reg & ~M_TIM2) | (stReg.pwrReg & ~M_PWR) | (stReg.dspReg & ~M_DSP) |
         (stReg.intfReg & ~M_INT) | (stReg.inteReg & ~M_INT)) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

// *** tb/lcr_panel_model.sv ***
// panel-side timing model: oscillator ticks and frame switch pulses
// assumes one core_clk domain shared with the register bank
module lcr_panel_model (
    input  wire logic       core_clk,
    input  wire logic       tickOn,
    input  wire logic       opClkEn,
    output logic [3:0]      srcTick,
    output logic            frameSwitch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       phase   = 1'b0;  // oscillator phase
    logic [2:0] lineCnt = 3'h0;  // operating clocks within the frame
    // sources tick on alternate cycles; a frame spans eight operating clocks
    always_ff @(posedge core_clk) begin
        phase       <= !phase;
        srcTick     <= {4{tickOn & phase}};
        // unknown enable before reset must not poison the line count
        if (opClkEn) begin
            lineCnt <= lineCnt + 3'h1;
        end
        frameSwitch <= opClkEn && (lineCnt == 3'h7);
    end
endmodule

// *** tb/lcd_driver_control_regs_bench.sv ***
// self-checking bench of the display driver register bank
// assumes the panel timing model supplies ticks and frame switches
module lcd_driver_control_regs_bench import lcr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, tickOn = 1'b0, dbgHalt = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'h0, srcTick;
    logic        awready, wready, arready, bvalid, rvalid, irqReq, opClkEn, frameSwitch;
    logic        pinsDriveLow, pinsHiZ, bstClkEn;
    wire  [26:0] fld;  // field outputs, frame rate at the top, area select at bit 0
    logic [1:0]  bresp, rresp, dspMode;
    logic [15:0] comEn, rnd;
    logic [33:0] rdQ[$];  // expected read answers
    logic [1:0]  wrQ[$];  // expected write responses
    int          bad_count = 0, cmp_count = 0, cycles = 0, seed = 4812, nTick, nOp, nBst;
    localparam logic [7:0]  ADR [9] = '{A_CLK, A_CTL, A_TIM1, A_TIM2, A_PWR, A_DSP, A_COM,
                                        A_INTF, A_INTE};
    localparam logic [15:0] RST [9] = '{R_CLK, R_CTL, R_TIM1, R_TIM2, R_PWR, R_DSP, R_COM,
                                        R_INT, R_INT};
    localparam logic [15:0] MSK [9] = '{M_CLK, M_CTL, M_TIM1, M_TIM2, M_PWR, M_DSP, M_COM,
                                        M_INT, M_INT};
    lcr_regs dut (
        .core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .srcTick(srcTick), .dbgHalt(dbgHalt), .frameSwitch(frameSwitch), .irqReq(irqReq),
        .opClkEn(opClkEn), .bstClkEn(bstClkEn), .frameRateSel(fld[26:22]),
        .driveDutySel(fld[21:18]), .inverseLineCount(fld[17:14]), .nLineInvertOn(fld[13]),
        .externalSupplySel(fld[12]), .contrastLevel(fld[11:8]), .boosterEnable(fld[7]),
        .biasSelect(fld[6]), .heavyLoadProtect(fld[5]), .regulatorEnable(fld[4]),
        .segmentOrder(fld[3]), .commonOrder(fld[2]), .displayInvertN(fld[1]),
        .displayAreaSel(fld[0]),
        .displayOnoffMode(dspMode), .pinsDriveLow(pinsDriveLow), .pinsHiZ(pinsHiZ),
        .commonPinDriveEn(comEn));
    lcr_panel_model panel (.core_clk(core_clk), .tickOn(tickOn), .opClkEn(opClkEn),
        .srcTick(srcTick), .frameSwitch(frameSwitch));
    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = !core_clk;
    end
    // value compare, counted
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // counts, verdict, end of run
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one write: address and data offered together, held until taken
    task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        logic ta, tw, b;
        @(posedge core_clk);
        wrQ.push_back(r);
        awaddr  <= a;
        wdata   <= {16'h0000, d};
        wstrb   <= 4'h3;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge core_clk);
            ta = awready;
            tw = wready;
            b  = bvalid;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
    endtask
    // one read, held until the answer is sampled
    task automatic axr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        logic ta, v;
        @(posedge core_clk);
        rdQ.push_back({r, 16'h0000, d});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge core_clk);
            ta = arready;
            v  = rvalid;
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
        end while (!v);
        rready <= 1'b0;
    endtask
    // answer watcher: oldest note against each handshake; tick and clock counts
    always @(negedge core_clk) begin
        if (rvalid && rready) chk({rresp, rdata}, rdQ.pop_front());
        if (bvalid && bready) chk(34'(bresp), 34'(wrQ.pop_front()));
        nTick = nTick + int'(srcTick[0]);
        nOp   = nOp + int'(opClkEn);
        nBst  = nBst + int'(bstClkEn);
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(34'({dspMode, pinsHiZ, pinsDriveLow}), 34'h0_0000_0002);
        chk(34'(fld), 34'h0_00FC_100E);
        for (int i = 0; i < 9; i++) axr(ADR[i], RST[i], RESP_OK);
        for (int i = 0; i < 9; i++) begin
            if (i != 1) begin
                axw(ADR[i], 16'hFFFF, RESP_OK);
                axr(ADR[i], (i == 7) ? 16'h0000 : MSK[i], RESP_OK);
            end
        end
        chk(34'(fld), 34'h0_07FF_FFFF);
        axw(8'h24, 16'hFFFF, RESP_ERR);
        axr(8'h24, 16'h0000, RESP_ERR);
        axw(A_CLK, 16'h0101, RESP_OK);
        axw(A_DSP, 16'h0071, RESP_OK);
        axw(A_TIM2, 16'h0000, RESP_OK);
        axw(A_CTL, 16'h0001, RESP_OK);
        axw(A_CLK, 16'h0000, RESP_OK);
        axr(A_CLK, 16'h0101, RESP_OK);
        nTick = 0;
        nOp = 0;
        nBst = 0;
        tickOn <= 1'b1;
        repeat (40) @(posedge core_clk);
        tickOn <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(34'(nOp), 34'(nTick));
        chk(34'(nBst), 34'(nTick / 4));
        chk(34'(irqReq), 34'h0_0000_0001);
        axw(A_CTL, 16'h0000, RESP_OK);
        axr(A_DSP, 16'h0070, RESP_OK);
        axw(A_PWR, 16'h0000, RESP_OK);
        axw(A_CTL, 16'h0002, RESP_OK);
        chk(34'({pinsHiZ, pinsDriveLow}), 34'h0_0000_0001);
        axw(A_INTF, 16'h0000, RESP_OK);
        axr(A_INTF, 16'h0001, RESP_OK);
        axw(A_INTF, 16'h0001, RESP_OK);
        axr(A_INTF, 16'h0000, RESP_OK);
        chk(34'(irqReq), 34'h0_0000_0000);
        for (int d = 0; d < 6; d++) begin
            axw(A_CLK, {7'h00, 1'b1, 1'b0, d[2:0], 2'h0, d[0] ? SRC_HIGH : SRC_INT}, RESP_OK);
            axw(A_CTL, 16'h0001, RESP_OK);
            nTick = 0;
            nOp = 0;
            dbgHalt <= d[0];
            tickOn <= 1'b1;
            repeat (1100) @(posedge core_clk);
            tickOn <= 1'b0;
            repeat (4) @(posedge core_clk);
            chk(34'(nOp), 34'(nTick / (16 << d)));
            axw(A_CTL, 16'h0000, RESP_OK);
        end
        // debug halt with debug-run cleared stops the clock, release restarts it
        axw(A_CLK, 16'h0001, RESP_OK);
        axw(A_CTL, 16'h0001, RESP_OK);
        nOp = 0;
        tickOn <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk(34'(nOp), 34'h0_0000_0000);
        dbgHalt <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk(34'(nOp > 0), 34'h0_0000_0001);
        tickOn <= 1'b0;
        repeat (3) begin
            rnd = 16'($random(seed));
            axw(A_COM, rnd, RESP_OK);
            chk(34'(comEn), 34'(rnd));
        end
        results();
    end
endmodule
